// [rtl/irh_top.sv]
// Interrupt request handler: latches requests, applies mask, mode and
// priority, and offers one acknowledge at a time to the CPU core.
// Assumes APB for software access; pin requests are asynchronous, peripheral
// requests are single-cycle pulses on pclk.
// Overview of operation
// RULE_01 - A masked source stays pending; no vectoring, no macro service.
// RULE_02 - Unmasked vectored-mode source with interrupts disabled stays pending.
// RULE_03 - Unmasked vectored source, context switch off, enabled: ordinary vectoring.
// RULE_04 - Unmasked source with mode select set is serviced by macro service.
// RULE_05 - Vectored, context switch and macro service selectable per source.
// RULE_06 - Nonmaskable class: pin request at 0002H, watchdog at 0004H.
// RULE_07 - Break at 003EH and undefined opcode trap at 003CH.
// RULE_08 - Maskable priorities 0 to 17, vectors 0006H up to 002AH.
// RULE_09 - Pin 5 shares compare-01 line at 0012H; pin 4 shares capture-X0.
// RULE_10 - UART receive and transmit done at 0024H and 0026H.
// RULE_11 - Synchronous serial done at priority 16, vector 0028H.
// RULE_12 - UART receive error is a test factor and never vectors.
// RULE_13 - Conversion done raises a request able to start macro service.
// RULE_14 - Watchdog overflow raises its nonmaskable request and drives error pin low.
// RULE_15 - Software clears the watchdog within the period in every module.
// RULE_16 - Context switching only when the source's enable bit is set.
// RULE_17 - Macro transfer clears the flag; exhausted counter yields a vectored request.
// RULE_18 - Three programmable priority levels for maskable requests.
// RULE_19 - Equal level: lowest default priority number wins.
// RULE_20 - Nonmaskable requests ignore global enable and mask bits.
`timescale 1ns/1ps
module irh_top
	import irh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_pin,
	input wire logic [6:0] ext_pin_request,
	input wire logic [NUM_SRC-1:0] periph_request,
	input wire logic uart_rx_error_test_request,
	input wire logic ack_taken,
	output logic ack_valid,
	output logic [15:0] ack_vector,
	output logic [1:0] ack_kind,
	output logic [4:0] ack_source,
	output logic uart_rx_error_flag,
	output logic watchdog_error_out_n
);
	typedef struct packed {
		logic [NUM_SRC-1:0] req;
		logic [NUM_SRC-1:0] mask;
		logic [NUM_SRC-1:0] mode;
		logic [NUM_SRC-1:0] context_switch_enable;
		logic [2*NUM_SRC-1:0] prio;
		logic gie;
		logic nmi_pend;
		logic wdt_pend;
		logic brk_pend;
		logic trap_pend;
		logic [4:0] xsel;
		logic [15:0] wdt_period;
		logic [6:0] pin_prev;
		logic nmi_prev;
		logic wdt_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic ack_valid;
		logic [15:0] ack_vector;
		logic [1:0] ack_kind;
		logic [4:0] ack_source;
		logic rxerr;
		logic wdt_err;
	} irh_st_type;
	irh_st_type st_reg, st_next;

	logic [7:0] xcnt_mem [NUM_SRC];
	logic [6:0] pin_s;
	logic nmi_s;
	irh_wdt_if wif();

	irh_sync #(.W(8)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({nmi_pin, ext_pin_request}),
		.dout({nmi_s, pin_s})
	);

	irh_wdt u_wdt (
		.pclk(pclk),
		.presetn(presetn),
		.w(wif.wdt)
	);

	wire apb_wr = psel && penable && pwrite && !st_reg.pready;
	wire apb_rd = psel && penable && !pwrite && !st_reg.pready;
	assign wif.clear = apb_wr && paddr == ADDR_CTRL && pwdata[CTRL_WDT_CLR];
	assign wif.period = st_reg.wdt_period;

	// Returns the source that should be offered next among eligible ones.
	function automatic logic [5:0] pick(input logic [NUM_SRC-1:0] elig,
		input logic [2*NUM_SRC-1:0] prio);
		logic [5:0] r;
		logic [1:0] best;
		r = 6'h3f;
		best = 2'h3;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (elig[i] && prio[2*i +: 2] < best) begin // [RULE_18] [RULE_19]
				best = prio[2*i +: 2];
				r = 6'(i);
			end
		end
		return r;
	endfunction

	// A macro-mode source is served by macro service while its counter is nonzero.
	function automatic logic macro_due(input logic mode_bit, input logic [7:0] cnt);
		return mode_bit && cnt != 8'h00;
	endfunction

	logic [NUM_SRC-1:0] raw;
	logic [NUM_SRC-1:0] elig;
	logic [5:0] win;
	logic [4:0] w5;
	logic grant_mask;

	always_comb begin
		// Pins 0..6 map onto sources 1..7; pins 4 and 5 share lines with
		// capture-X0 at source 5 and compare-01 at source 6.
		raw = periph_request; // [RULE_09] [RULE_10] [RULE_11] [RULE_13]
		for (int p = 0; p < 7; p++) begin
			if (pin_s[p] && !st_reg.pin_prev[p]) begin
				raw[p+1] = 1'b1;
			end
		end
		for (int i = 0; i < NUM_SRC; i++) begin
			// Masked sources are never eligible; vectored ones need global enable.
			elig[i] = st_reg.req[i] && !st_reg.mask[i] // [RULE_01]
				&& (st_reg.mode[i] || st_reg.gie); // [RULE_02] [RULE_04]
		end
		win = pick(elig, st_reg.prio);
		w5 = win[4:0];
		// A maskable source is granted only when no offer or higher class is pending.
		grant_mask = !st_reg.ack_valid && !st_reg.nmi_pend && !st_reg.wdt_pend
			&& !st_reg.trap_pend && !st_reg.brk_pend && !win[5];
	end

	always_comb begin
		st_next = st_reg;
		st_next.pin_prev = pin_s;
		st_next.nmi_prev = nmi_s;
		st_next.wdt_prev = wif.overflow;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		if (wif.clear) begin
			st_next.wdt_err = 1'b0;
		end

		// Acknowledge handshake: the offer stands until the core takes it.
		if (st_reg.ack_valid && ack_taken) begin
			st_next.ack_valid = 1'b0;
		end else if (!st_reg.ack_valid) begin
			if (st_reg.nmi_pend) begin
				st_next.nmi_pend = 1'b0;
				st_next.ack_valid = 1'b1; // [RULE_20]
				st_next.ack_vector = VEC_NMI;
				st_next.ack_kind = KIND_VECTOR;
				st_next.ack_source = 5'h1f;
			end else if (st_reg.wdt_pend) begin
				st_next.wdt_pend = 1'b0;
				st_next.ack_valid = 1'b1; // [RULE_20]
				st_next.ack_vector = VEC_WDT;
				st_next.ack_kind = KIND_VECTOR;
				st_next.ack_source = 5'h1e;
			end else if (st_reg.trap_pend) begin
				st_next.trap_pend = 1'b0;
				st_next.ack_valid = 1'b1; // [RULE_07]
				st_next.ack_vector = VEC_TRAP;
				st_next.ack_kind = KIND_VECTOR;
				st_next.ack_source = 5'h1d;
			end else if (st_reg.brk_pend) begin
				st_next.brk_pend = 1'b0;
				st_next.ack_valid = 1'b1; // [RULE_07]
				st_next.ack_vector = VEC_BRK;
				st_next.ack_kind = KIND_VECTOR;
				st_next.ack_source = 5'h1c;
			end else if (!win[5]) begin
				st_next.req[w5] = 1'b0; // [RULE_17]
				st_next.ack_source = w5;
				st_next.ack_valid = 1'b1;
				st_next.ack_vector = irh_vector(w5); // [RULE_08]
				if (macro_due(st_reg.mode[w5], xcnt_mem[w5])) begin
					st_next.ack_kind = KIND_MACRO; // [RULE_04] [RULE_05]
				end else if (st_reg.context_switch_enable[w5]) begin
					st_next.ack_kind = KIND_CTXSW; // [RULE_16]
				end else begin
					st_next.ack_kind = KIND_VECTOR; // [RULE_03] [RULE_17]
				end
			end
		end

		// New events win over any clear in the same cycle.
		if (apb_wr) begin
			st_next.pready = 1'b1;
			case (paddr)
				ADDR_REQ: st_next.req = st_next.req & ~pwdata[NUM_SRC-1:0];
				ADDR_MASK: st_next.mask = pwdata[NUM_SRC-1:0];
				ADDR_MODE: st_next.mode = pwdata[NUM_SRC-1:0];
				ADDR_CSE: st_next.context_switch_enable = pwdata[NUM_SRC-1:0];
				ADDR_PRIO_LO: st_next.prio[31:0] = pwdata;
				ADDR_PRIO_HI: st_next.prio[35:32] = pwdata[3:0];
				ADDR_CTRL: begin
					st_next.gie = pwdata[CTRL_GIE];
					if (pwdata[CTRL_SWI_BRK]) begin
						st_next.brk_pend = 1'b1;
					end
					if (pwdata[CTRL_SWI_TRAP]) begin
						st_next.trap_pend = 1'b1;
					end
				end
				ADDR_ACK: st_next.rxerr = st_next.rxerr & ~pwdata[0];
				ADDR_XCNT_SEL: st_next.xsel = pwdata[4:0];
				ADDR_XCNT: begin
				end
				ADDR_WDT: st_next.wdt_period = pwdata[15:0];
				default: st_next.pslverr = 1'b1;
			endcase
		end else if (apb_rd) begin
			st_next.pready = 1'b1;
			st_next.prdata = 32'h0000_0000;
			case (paddr)
				ADDR_REQ: st_next.prdata = 32'(st_reg.req);
				ADDR_MASK: st_next.prdata = 32'(st_reg.mask);
				ADDR_MODE: st_next.prdata = 32'(st_reg.mode);
				ADDR_CSE: st_next.prdata = 32'(st_reg.context_switch_enable);
				ADDR_PRIO_LO: st_next.prdata = st_reg.prio[31:0];
				ADDR_PRIO_HI: st_next.prdata = 32'(st_reg.prio[35:32]);
				ADDR_CTRL: st_next.prdata = 32'(st_reg.gie);
				ADDR_ACK: st_next.prdata = 32'(st_reg.rxerr);
				ADDR_XCNT_SEL: st_next.prdata = 32'(st_reg.xsel);
				ADDR_XCNT: st_next.prdata = 32'(xcnt_mem[st_reg.xsel]);
				ADDR_WDT: st_next.prdata = 32'(st_reg.wdt_period);
				ADDR_STATUS: st_next.prdata = {wif.count, 8'h00, 1'b0,
					st_reg.wdt_err, st_reg.brk_pend, st_reg.trap_pend,
					st_reg.wdt_pend, st_reg.nmi_pend, 2'h0};
				default: st_next.pslverr = 1'b1;
			endcase
		end
		st_next.req = st_next.req | raw;
		// Events are applied last so that they win over an acknowledge or a clear.
		// Receive error is only a test flag; it never reaches the vector logic.
		st_next.rxerr = st_next.rxerr | uart_rx_error_test_request; // [RULE_12]
		if (wif.overflow && !st_reg.wdt_prev) begin
			st_next.wdt_pend = 1'b1; // [RULE_06]
			st_next.wdt_err = 1'b1; // [RULE_14]
		end
		if (nmi_s && !st_reg.nmi_prev) begin
			st_next.nmi_pend = 1'b1; // [RULE_06]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.mask <= MASK_RST;
			st_reg.prio <= {NUM_SRC{PRIO_LOWEST}};
			st_reg.wdt_period <= WDT_PERIOD_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Transfer counters: write loads the selected one; a macro acknowledge
	// decrements it, and at zero the next acknowledge is context-switched if its enable bit is set, else vectored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				xcnt_mem[i] <= 8'h00;
			end
		end else begin
			if (grant_mask && macro_due(st_reg.mode[w5], xcnt_mem[w5])) begin
				xcnt_mem[w5] <= xcnt_mem[w5] - 8'h01; // [RULE_17]
			end
			if (apb_wr && paddr == ADDR_XCNT) begin
				xcnt_mem[st_reg.xsel] <= pwdata[7:0];
			end
		end
	end
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign ack_valid = st_reg.ack_valid;
	assign ack_vector = st_reg.ack_vector;
	assign ack_kind = st_reg.ack_kind;
	assign ack_source = st_reg.ack_source;
	assign uart_rx_error_flag = st_reg.rxerr;
	assign watchdog_error_out_n = !st_reg.wdt_err; // [RULE_14]
endmodule

// [rtl/irh_pkg.sv]
// Package for the interrupt request handler: register map, vector table, timing.
// Assumes a 40 MHz pclk and an APB slave with 32-bit data.
package irh_pkg;
	localparam int unsigned NUM_SRC = 18;
	localparam int unsigned CLK_MHZ = 40;
	// Register byte offsets.
	localparam logic [7:0] ADDR_REQ = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_CSE = 8'h0c;
	localparam logic [7:0] ADDR_PRIO_LO = 8'h10;
	localparam logic [7:0] ADDR_PRIO_HI = 8'h14;
	localparam logic [7:0] ADDR_CTRL = 8'h18;
	localparam logic [7:0] ADDR_ACK = 8'h1c;
	localparam logic [7:0] ADDR_XCNT_SEL = 8'h20;
	localparam logic [7:0] ADDR_XCNT = 8'h24;
	localparam logic [7:0] ADDR_WDT = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h2c;
	// Control register fields.
	localparam int unsigned CTRL_GIE = 0;
	localparam int unsigned CTRL_WDT_CLR = 1;
	localparam int unsigned CTRL_SWI_BRK = 2;
	localparam int unsigned CTRL_SWI_TRAP = 3;
	// Reset values.
	localparam logic [17:0] MASK_RST = 18'h3ffff;
	localparam logic [15:0] WDT_PERIOD_RST = 16'hffff;
	localparam logic [1:0] PRIO_LOWEST = 2'h2;
	// Vectors.
	localparam logic [15:0] VEC_NMI = 16'h0002;
	localparam logic [15:0] VEC_WDT = 16'h0004;
	localparam logic [15:0] VEC_MASK_BASE = 16'h0006;
	localparam logic [15:0] VEC_TRAP = 16'h003c;
	localparam logic [15:0] VEC_BRK = 16'h003e;
	localparam logic [15:0] VEC_UART_RX = 16'h0024;
	localparam int unsigned IDX_UART_RX = 14;
	// Acknowledge kinds.
	localparam logic [1:0] KIND_VECTOR = 2'h0;
	localparam logic [1:0] KIND_CTXSW = 2'h1;
	localparam logic [1:0] KIND_MACRO = 2'h2;
	// Watchdog prescaler: one watchdog tick per microsecond.
	localparam int unsigned WDT_TICK_NS = 1000;
	localparam int unsigned WDT_TICK_CYC = (WDT_TICK_NS * CLK_MHZ) / 1000;
	localparam logic [5:0] WDT_PRE_LAST = 6'(WDT_TICK_CYC - 1);

	// Vector address of maskable source idx; the slot at 0022H is skipped.
	function automatic logic [15:0] irh_vector(input logic [4:0] idx);
		logic [15:0] v;
		v = VEC_MASK_BASE + {10'h000, idx, 1'b0};
		if (idx >= 5'(IDX_UART_RX)) begin
			v = v + 16'h0002;
		end
		return v;
	endfunction
endpackage

// [rtl/irh_if.sv]
// Interface carrying the watchdog link between the handler and its watchdog.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface irh_wdt_if;
	logic clear;
	logic [15:0] period;
	logic overflow;
	logic [15:0] count;
	modport ctl(output clear, output period, input overflow, input count);
	modport wdt(input clear, input period, output overflow, output count);
endinterface

// [rtl/irh_wdt.sv]
// Watchdog counter: a prescaled up-counter that flags overflow once.
// Assumes a clear from the handler restarts the count.
`timescale 1ns/1ps
module irh_wdt
	import irh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	irh_wdt_if.wdt w
);
	typedef struct packed {
		logic [5:0] pre;
		logic [15:0] cnt;
		logic ovf;
	} irh_wdt_st_type;
	irh_wdt_st_type st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		if (w.clear) begin
			st_next = '0;
		end else if (!st_reg.ovf) begin
			if (st_reg.pre == WDT_PRE_LAST) begin
				st_next.pre = '0;
				if (st_reg.cnt == w.period) begin
					st_next.ovf = 1'b1; // [RULE_14]
				end else begin
					st_next.cnt = st_reg.cnt + 16'h0001;
				end
			end else begin
				st_next.pre = st_reg.pre + 6'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign w.overflow = st_reg.ovf;
	assign w.count = st_reg.cnt;
endmodule

// [rtl/irh_sync.sv]
// Three-stage synchroniser bank for pin inputs.
// A change counts once the second and third stage agree.
`timescale 1ns/1ps
module irh_sync #(
	parameter int unsigned W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} irh_sync_st_type;
	irh_sync_st_type st_reg, st_next;

	always_comb begin
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.q = st_reg.q;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.q;
endmodule

// [tb/irh_top_props.sv]
// Checker on the handler top-level ports.
// Assumes one pclk domain with active-low asynchronous presetn.
`timescale 1ns/1ps
module irh_top_props
	import irh_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic ack_taken,
	input wire logic ack_valid,
	input wire logic [15:0] ack_vector,
	input wire logic [1:0] ack_kind,
	input wire logic [4:0] ack_source,
	input wire logic watchdog_error_out_n
);
	logic [15:0] tbl_vec;
	// The slot at 0022H is skipped from the receive-done source onwards.
	assign tbl_vec = 16'h0006 + {10'h000, ack_source, 1'b0}
		+ ((ack_source >= 5'd14) ? 16'h0002 : 16'h0000);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_after_access: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_offer_holds: assert property (ack_valid && !ack_taken |=> ack_valid
		&& $stable(ack_vector) && $stable(ack_source) && $stable(ack_kind))
		else $error("offer changed");
	a_gap_after_take: assert property (ack_valid && ack_taken |=> !ack_valid)
		else $error("no gap");
	a_nmi_vector: assert property (
		ack_valid && ack_source == 5'd31 |-> ack_vector == 16'h0002)
		else $error("nmi vector");
	a_wdt_vector: assert property (
		ack_valid && ack_source == 5'd30 |-> ack_vector == 16'h0004)
		else $error("watchdog vector");
	a_soft_vectors: assert property (
		ack_valid && ack_source inside {5'd28, 5'd29}
		|-> ack_vector == ((ack_source == 5'd28) ? 16'h003e : 16'h003c))
		else $error("software vector");
	a_mask_table: assert property (
		ack_valid && ack_source <= 5'd17 && ack_kind == KIND_VECTOR |-> ack_vector == tbl_vec)
		else $error("maskable vector");
	a_wdt_pin_request: assert property (
		$fell(watchdog_error_out_n) |-> ##[0:40] (ack_valid && ack_source == 5'd30))
		else $error("watchdog request missing");
	c_macro: cover property (ack_valid && ack_kind == KIND_MACRO);
	c_ctxsw: cover property (ack_valid && ack_kind == KIND_CTXSW);
	c_wdt: cover property (!watchdog_error_out_n && ack_taken);
endmodule
bind irh_top irh_top_props u_props (.pclk, .presetn, .psel, .penable, .pready,
	.ack_taken, .ack_valid, .ack_vector, .ack_kind, .ack_source, .watchdog_error_out_n);

// [tb/irh_core_model.sv]
// Behavioural CPU core that takes the handler's acknowledge offers.
// Assumes an offer stands until the cycle in which it is taken.
`timescale 1ns/1ps
module irh_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ack_valid,
	input wire logic [15:0] ack_vector,
	input wire logic [1:0] ack_kind,
	input wire logic [4:0] ack_source,
	input wire logic [2:0] core_delay,
	output logic ack_taken,
	output logic [15:0] got_vec,
	output logic [1:0] got_kind,
	output logic [4:0] got_src,
	output int got_count
);
	logic [2:0] wait_cnt;
	// The core lets core_delay cycles pass before taking, so prompt and slow takes occur.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_taken <= 1'b0;
			wait_cnt <= 3'h0;
			got_count <= 0;
		end else if (ack_taken) begin
			ack_taken <= 1'b0;
			wait_cnt <= 3'h0;
			got_vec <= ack_vector;
			got_kind <= ack_kind;
			got_src <= ack_source;
			got_count <= got_count + 1;
		end else if (ack_valid && wait_cnt >= core_delay) begin
			ack_taken <= 1'b1;
		end else if (ack_valid) begin
			wait_cnt <= wait_cnt + 3'h1;
		end
	end
endmodule

// [tb/irh_top_test.sv]
// Self-checking bench for the interrupt request handler.
// Assumes APB with one wait state and a core model taking acknowledges.
`timescale 1ns/1ps
module irh_top_test
	import irh_pkg::*;
();
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nmi_pin, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [6:0] ext_pin_request;
	logic [NUM_SRC-1:0] periph_request, b;
	logic uart_rx_error_test_request, ack_taken, ack_valid, uart_rx_error_flag;
	logic watchdog_error_out_n;
	logic [15:0] ack_vector, got_vec;
	logic [1:0] ack_kind, got_kind;
	logic [4:0] ack_source, got_src;
	logic [2:0] core_delay;
	int got_count, seen, fails, comparisons, seed, m;
	irh_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .nmi_pin, .ext_pin_request, .periph_request,
		.uart_rx_error_test_request, .ack_taken, .ack_valid, .ack_vector, .ack_kind,
		.ack_source, .uart_rx_error_flag, .watchdog_error_out_n);
	irh_core_model core (.pclk, .presetn, .ack_valid, .ack_vector, .ack_kind, .ack_source,
		.core_delay, .ack_taken, .got_vec, .got_kind, .got_src, .got_count);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic test_done();
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input logic [17:0] v);
		@(posedge pclk);
		periph_request <= v;
		@(posedge pclk);
		periph_request <= '0;
	endtask
	function automatic logic [15:0] vec_of(input int i);
		return 16'h0006 + 16'(2 * i) + ((i >= 14) ? 16'h0002 : 16'h0000);
	endfunction
	task automatic expect_ack(input logic [4:0] s, input logic [1:0] k, input logic [15:0] v);
		int n;
		n = 0;
		core_delay <= 3'($random(seed));
		while (got_count <= seen && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (got_count <= seen) begin
			fails++;
			test_done();
		end
		seen++;
		cmp(32'(s), 32'(got_src));
		cmp(32'(k), 32'(got_kind));
		if (k != KIND_MACRO) cmp(32'(v), 32'(got_vec));
	endtask
	initial begin
		seed = 5;
		seen = 0;
		fails = 0;
		comparisons = 0;
		{presetn, psel, penable, pwrite, nmi_pin, uart_rx_error_test_request} = '0;
		{paddr, pwdata, ext_pin_request, periph_request, core_delay} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		cmp(32'h1, 32'(watchdog_error_out_n));
		apb(1'b0, ADDR_MASK, 32'h0);
		cmp(32'(MASK_RST), r);
		apb(1'b0, 8'h30, 32'h0);
		cmp(32'h1, {r[30:0], e});
		apb(1'b1, ADDR_CTRL, 32'h1);
		pulse(18'h00008);
		repeat (20) @(posedge pclk);
		cmp(seen, got_count);
		apb(1'b0, ADDR_REQ, 32'h0);
		cmp(32'h8, r & 32'h8);
		apb(1'b1, ADDR_MASK, 32'h3fff7);
		expect_ack(5'd3, KIND_VECTOR, vec_of(3));
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h0);
		pulse(18'h00020);
		repeat (20) @(posedge pclk);
		cmp(seen, got_count);
		apb(1'b1, ADDR_CTRL, 32'h1);
		expect_ack(5'd5, KIND_VECTOR, vec_of(5));
		for (int i = 0; i < 18; i++) begin
			m = (i == 17) ? 2 : ((i == 14) ? 1 : int'($unsigned($random(seed)) % 3));
			b = 18'(1) << i;
			apb(1'b1, ADDR_MODE, (m == 2) ? 32'(b) : 32'h0);
			apb(1'b1, ADDR_CSE, (m == 1) ? 32'(b) : 32'h0);
			apb(1'b1, ADDR_XCNT_SEL, 32'(i));
			apb(1'b1, ADDR_XCNT, 32'h1);
			pulse(b);
			expect_ack(5'(i), 2'(m), vec_of(i));
			if (m == 2) begin
				apb(1'b0, ADDR_REQ, 32'h0);
				cmp(32'h0, r & 32'(b));
				pulse(b);
				expect_ack(5'(i), KIND_VECTOR, vec_of(i));
			end
		end
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, ADDR_MODE, 32'h0);
		apb(1'b1, ADDR_CSE, 32'h0);
		apb(1'b1, ADDR_PRIO_LO, 32'haaa2aaaa);
		pulse(18'h00214);
		apb(1'b1, ADDR_CTRL, 32'h1);
		expect_ack(5'd9, KIND_VECTOR, vec_of(9));
		expect_ack(5'd2, KIND_VECTOR, vec_of(2));
		expect_ack(5'd4, KIND_VECTOR, vec_of(4));
		apb(1'b1, ADDR_MASK, 32'h3ffff);
		apb(1'b1, ADDR_CTRL, 32'h0);
		nmi_pin <= 1'b1;
		expect_ack(5'd31, KIND_VECTOR, 16'h0002);
		apb(1'b1, ADDR_MASK, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		ext_pin_request <= 7'h20;
		expect_ack(5'd6, KIND_VECTOR, 16'h0012);
		ext_pin_request <= 7'h30;
		expect_ack(5'd5, KIND_VECTOR, 16'h0010);
		apb(1'b1, ADDR_CTRL, 32'h5);
		expect_ack(5'd28, KIND_VECTOR, 16'h003e);
		apb(1'b1, ADDR_CTRL, 32'h9);
		expect_ack(5'd29, KIND_VECTOR, 16'h003c);
		uart_rx_error_test_request <= 1'b1;
		@(posedge pclk);
		uart_rx_error_test_request <= 1'b0;
		repeat (20) @(posedge pclk);
		cmp(seen, got_count);
		cmp(32'h1, 32'(uart_rx_error_flag));
		apb(1'b1, ADDR_ACK, 32'h1);
		repeat (2) @(posedge pclk);
		cmp(32'h0, 32'(uart_rx_error_flag));
		apb(1'b1, ADDR_WDT, 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h3);
		apb(1'b1, ADDR_CTRL, 32'h1);
		expect_ack(5'd30, KIND_VECTOR, 16'h0004);
		cmp(32'h0, 32'(watchdog_error_out_n));
		apb(1'b1, ADDR_CTRL, 32'h3);
		repeat (2) @(posedge pclk);
		cmp(32'h1, 32'(watchdog_error_out_n));
		test_done();
	end
endmodule
